/* File: rtl/lcc_top.sv */
// logic cell array with hard and routed clock networks, ahb-lite registers
//
// Local design decisions: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module lcc_top #(
   parameter int NUM_CELLS = 4
) (
   // ahb-lite slave
   input  wire logic                 hclk,
   input  wire logic                 hresetn,
   input  wire logic                 hsel,
   input  wire logic [7:0]           haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic [31:0]          hwdata,
   input  wire logic                 hready,
   output logic [31:0]               hrdata,
   output logic                      hreadyout,
   output logic [1:0]                hresp,
   // clock pins, sampled on hclk
   input  wire logic                 hard_clock_pin,
   input  wire logic                 routed_clock_a,
   input  wire logic                 routed_clock_b,
   input  wire logic                 test_reset_pin,
   // register cells
   input  wire logic [NUM_CELLS-1:0] cell_d,
   input  wire logic [NUM_CELLS-1:0] enable_select_lo,
   input  wire logic [NUM_CELLS-1:0] enable_select_hi,
   input  wire logic [NUM_CELLS-1:0] cell_clear,
   input  wire logic [NUM_CELLS-1:0] cell_preset,
   output logic [NUM_CELLS-1:0]      cell_q,
   // combinational cells, bit 0 of each is the invertible input
   input  wire logic [4:0]           comb0_in,
   input  wire logic [4:0]           comb1_in,
   output logic [1:0]                comb_out,
   // paired cell register
   input  wire logic                 pair_d,
   output logic                      paired_cell_register
);
   // ----------------------------------------
   // bus slave
   // ----------------------------------------
   logic [31:0]          clk_ctrl_reg;
   logic [31:0]          comb_ctrl_reg;
   logic [31:0]          lut0_reg;
   logic [31:0]          lut1_reg;
   logic [31:0]          cell_cfg_reg;
   logic [31:0]          hrdata_reg;
   logic                 wr_pend_reg;
   logic [7:0]           wr_addr_reg;
   logic                 take;
   logic [31:0]          rd_mux;
   logic [31:0]          status;
   logic [1:0]           comb_out_reg;
   logic                 hard_live;

   assign take = hsel && hready && htrans[1];
   assign hreadyout = 1'b1;
   assign hresp = lcc_pkg::RESP_OKAY;
   assign hrdata = hrdata_reg;

   always_comb begin
      status = '0;
      status[NUM_CELLS-1:0] = cell_q;
      status[lcc_pkg::ST_PAIR_BIT] = paired_cell_register;
      status[lcc_pkg::ST_LIVE_BIT] = hard_live;
      status[lcc_pkg::ST_COMB_LO +: 2] = comb_out_reg;
   end

   always_comb begin
      case ({haddr[7:2], 2'b00})
         lcc_pkg::CLK_CTRL_OFS:  rd_mux = clk_ctrl_reg;
         lcc_pkg::COMB_CTRL_OFS: rd_mux = comb_ctrl_reg;
         lcc_pkg::COMB0_LUT_OFS: rd_mux = lut0_reg;
         lcc_pkg::COMB1_LUT_OFS: rd_mux = lut1_reg;
         lcc_pkg::CELL_CFG_OFS:  rd_mux = cell_cfg_reg;
         lcc_pkg::STATUS_OFS:    rd_mux = status;
         default:                rd_mux = 32'h0000_0000;
      endcase
   end

   // read data is caught in the address phase; no wait states ever
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_reg  <= 32'h0000_0000;
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
      end else begin
         wr_pend_reg <= take && hwrite;
         if (take) begin
            wr_addr_reg <= {haddr[7:2], 2'b00};
         end
         if (take && !hwrite) begin
            hrdata_reg <= rd_mux;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         clk_ctrl_reg  <= lcc_pkg::CTRL_RST;
         comb_ctrl_reg <= lcc_pkg::CTRL_RST;
         lut0_reg      <= lcc_pkg::LUT_RST;
         lut1_reg      <= lcc_pkg::LUT_RST;
         cell_cfg_reg  <= lcc_pkg::CTRL_RST;
      end else if (wr_pend_reg) begin
         case (wr_addr_reg)
            lcc_pkg::CLK_CTRL_OFS:  clk_ctrl_reg  <= hwdata;
            lcc_pkg::COMB_CTRL_OFS: comb_ctrl_reg <= hwdata;
            lcc_pkg::COMB0_LUT_OFS: lut0_reg      <= hwdata;
            lcc_pkg::COMB1_LUT_OFS: lut1_reg      <= hwdata;
            lcc_pkg::CELL_CFG_OFS:  cell_cfg_reg  <= hwdata;
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // combinational cells
   // ----------------------------------------
   logic [4:0]  idx0;
   logic [4:0]  idx1;
   logic        lvl_a_reg;
   logic        lvl_b_reg;

   // routed levels may stand in for input 4
   // the hard network never reaches this path
   always_comb begin
      idx0 = comb0_in;
      idx1 = comb1_in;
      idx0[0] = comb0_in[0] ^ comb_ctrl_reg[lcc_pkg::INV0_BIT];
      idx1[0] = comb1_in[0] ^ comb_ctrl_reg[lcc_pkg::INV1_BIT];
      if (comb_ctrl_reg[lcc_pkg::C0_ROUTED_CLOCK_B_BIT])
         idx0[4] = lvl_b_reg;
      if (comb_ctrl_reg[lcc_pkg::C1_ROUTED_CLOCK_A_BIT])
         idx1[4] = lvl_a_reg;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         comb_out_reg <= 2'h0;
      else
         comb_out_reg <= {lut1_reg[idx1], lut0_reg[idx0]};
   end
   assign comb_out = comb_out_reg;

   // ----------------------------------------
   // clock networks
   // ----------------------------------------
   logic        hard_lvl_reg;
   logic        hard_prev_reg;
   logic        a_prev_reg;
   logic        b_prev_reg;
   logic [1:0]  hard_cnt_reg;
   logic        strap_low_reg;
   logic        strap_done_reg;
   logic        hard_rise_raw;
   logic [2:0]  net_rise;
   logic [2:0]  net_fall;

   // pin or internal buffer; registered so no logic loop forms
   // the unused pin is simply ignored here
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lvl_a_reg     <= 1'b0;
         lvl_b_reg     <= 1'b0;
         hard_lvl_reg  <= 1'b0;
         hard_prev_reg <= 1'b0;
         a_prev_reg    <= 1'b0;
         b_prev_reg    <= 1'b0;
      end else begin
         lvl_a_reg <= clk_ctrl_reg[lcc_pkg::A_INT_BIT] ? comb_out_reg[0] : routed_clock_a;
         lvl_b_reg <= clk_ctrl_reg[lcc_pkg::B_INT_BIT] ? comb_out_reg[1] : routed_clock_b;
         hard_lvl_reg  <= hard_clock_pin;
         hard_prev_reg <= hard_lvl_reg;
         a_prev_reg    <= lvl_a_reg;
         b_prev_reg    <= lvl_b_reg;
      end
   end

   // strap is caught once, on the first edge after reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         strap_low_reg  <= 1'b0;
         strap_done_reg <= 1'b0;
      end else if (!strap_done_reg) begin
         strap_low_reg  <= !test_reset_pin;
         strap_done_reg <= 1'b1;
      end
   end

   assign hard_rise_raw = hard_lvl_reg && !hard_prev_reg;
   assign hard_live = strap_low_reg || (hard_cnt_reg == lcc_pkg::HW_SUPPRESS_EDGES);

   // swallow the first three hard clock rises and the first two falls
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         hard_cnt_reg <= 2'h0;
      else if (hard_rise_raw && !hard_live)
         hard_cnt_reg <= hard_cnt_reg + 2'h1;
   end

   assign net_rise[0] = hard_rise_raw && hard_live;
   assign net_fall[0] = !hard_lvl_reg && hard_prev_reg && hard_live;
   assign net_rise[1] = lvl_a_reg && !a_prev_reg;
   assign net_fall[1] = !lvl_a_reg && a_prev_reg;
   assign net_rise[2] = lvl_b_reg && !b_prev_reg;
   assign net_fall[2] = !lvl_b_reg && b_prev_reg;

   // ----------------------------------------
   // register cells
   // ----------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < NUM_CELLS; gi++) begin : g_cell
         // per-cell source and polarity from the config word
         lcc_reg_cell u_cell (
            .hclk             (hclk),
            .hresetn          (hresetn),
            .net_rise         (net_rise),
            .net_fall         (net_fall),
            .src_sel          (cell_cfg_reg[gi*lcc_pkg::CFG_STRIDE+1 +: 2]),
            .falling          (cell_cfg_reg[gi*lcc_pkg::CFG_STRIDE]),
            .d                (cell_d[gi]),
            .enable_select_lo (enable_select_lo[gi]),
            .enable_select_hi (enable_select_hi[gi]),
            .clear            (cell_clear[gi]),
            .preset           (cell_preset[gi]),
            .q                (cell_q[gi])
         );
      end
   endgenerate

   // ----------------------------------------
   // paired cell register
   // ----------------------------------------
   logic [1:0]  pair_src;
   logic        pair_lvl;
   logic        pair_master_reg;
   logic        pair_slave_reg;

   // no slower than a real cell: the slave loads on the same hclk that a cell's edge_hit loads q_reg
   assign pair_src = clk_ctrl_reg[lcc_pkg::PAIR_SRC_LO +: 2];
   always_comb begin
      case (pair_src)
         lcc_pkg::SRC_A: pair_lvl = lvl_a_reg;
         lcc_pkg::SRC_B: pair_lvl = lvl_b_reg;
         default:        pair_lvl = hard_live && hard_lvl_reg;
      endcase
   end

   // master transparent on one level, slave on the other
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pair_master_reg <= 1'b0;
         pair_slave_reg  <= 1'b0;
      end else if ((pair_lvl ^ clk_ctrl_reg[lcc_pkg::PAIR_POL]) == 1'b0) begin
         pair_master_reg <= pair_d;
      end else begin
         pair_slave_reg <= pair_master_reg;
      end
   end
   assign paired_cell_register = pair_slave_reg;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_hard_gate;
      @(posedge hclk) disable iff (!hresetn)
         (!strap_low_reg && hard_cnt_reg != lcc_pkg::HW_SUPPRESS_EDGES) |-> !net_rise[0];
   endproperty
   a_hard_gate: assert property (p_hard_gate) else $error("hard edge passed too early");
   property p_hard_open;
      @(posedge hclk) disable iff (!hresetn)
         (hard_rise_raw && hard_cnt_reg == 2'h2 && !strap_low_reg) |=> hard_live;
   endproperty
   a_hard_open: assert property (p_hard_open) else $error("hard clock not live");
   property p_strap;
      @(posedge hclk) disable iff (!hresetn)
         (strap_done_reg && strap_low_reg && hard_rise_raw) |-> net_rise[0];
   endproperty
   a_strap: assert property (p_strap) else $error("strapped edge lost");
   property p_route_a;
      @(posedge hclk) disable iff (!hresetn)
         clk_ctrl_reg[lcc_pkg::A_INT_BIT] ##1 clk_ctrl_reg[lcc_pkg::A_INT_BIT]
         |-> lvl_a_reg == $past(comb_out_reg[0]);
   endproperty
   a_route_a: assert property (p_route_a) else $error("routed a source wrong");
   property p_comb0;
      @(posedge hclk) disable iff (!hresetn)
         ##1 comb_out_reg[0] == $past(lut0_reg[idx0]);
   endproperty
   a_comb0: assert property (p_comb0) else $error("lookup result wrong");
   property p_pair;
      @(posedge hclk) disable iff (!hresetn)
         (pair_slave_reg != $past(pair_slave_reg))
         |-> ($past(pair_lvl) ^ $past(clk_ctrl_reg[lcc_pkg::PAIR_POL]));
   endproperty
   a_pair: assert property (p_pair) else $error("paired cell moved off level");
   property p_okay;
      @(posedge hclk) disable iff (!hresetn) hreadyout && hresp == lcc_pkg::RESP_OKAY;
   endproperty
   a_okay: assert property (p_okay) else $error("bus answer not okay");
   property p_read;
      @(posedge hclk) disable iff (!hresetn)
         (take && !hwrite && {haddr[7:2], 2'b00} == lcc_pkg::COMB0_LUT_OFS)
         |=> hrdata == $past(lut0_reg);
   endproperty
   a_read: assert property (p_read) else $error("read data wrong");

   c_hard_live: cover property (@(posedge hclk) disable iff (!hresetn) net_rise[0]);
   c_route_int: cover property (@(posedge hclk) disable iff (!hresetn)
      clk_ctrl_reg[lcc_pkg::A_INT_BIT] && net_rise[1]);
   c_pair_out: cover property (@(posedge hclk) disable iff (!hresetn)
      paired_cell_register);
   c_comb_clk: cover property (@(posedge hclk) disable iff (!hresetn)
      comb_ctrl_reg[lcc_pkg::C1_ROUTED_CLOCK_A_BIT] && comb_out_reg[1]);
endmodule : lcc_top
`default_nettype wire

/* File: rtl/lcc_pkg.sv */
// shared constants for the logic cell clocking block
package lcc_pkg;
   // ----------------------------------------
   // register byte offsets
   // ----------------------------------------
   localparam logic [7:0] CLK_CTRL_OFS  = 8'h00;
   localparam logic [7:0] COMB_CTRL_OFS = 8'h04;
   localparam logic [7:0] COMB0_LUT_OFS = 8'h08;
   localparam logic [7:0] COMB1_LUT_OFS = 8'h0c;
   localparam logic [7:0] CELL_CFG_OFS  = 8'h10;
   localparam logic [7:0] STATUS_OFS    = 8'h14;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int A_INT_BIT   = 0;
   localparam int B_INT_BIT   = 1;
   localparam int PAIR_SRC_LO = 2;
   localparam int PAIR_POL    = 4;
   localparam int INV0_BIT    = 0;
   localparam int INV1_BIT    = 1;
   localparam int C0_ROUTED_CLOCK_B_BIT = 2;
   localparam int C1_ROUTED_CLOCK_A_BIT = 3;
   localparam int CFG_STRIDE  = 4;
   localparam int ST_PAIR_BIT = 8;
   localparam int ST_LIVE_BIT = 9;
   localparam int ST_COMB_LO  = 10;
   // ----------------------------------------
   // reset values and counts
   // ----------------------------------------
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] LUT_RST  = 32'h0000_0000;
   localparam logic [1:0]  HW_SUPPRESS_EDGES = 2'h3;
   localparam logic [1:0]  RESP_OKAY = 2'h0;
   // ----------------------------------------
   // clock network select
   // ----------------------------------------
   typedef enum logic [1:0] {
      SRC_HARD = 2'h0,
      SRC_A    = 2'h1,
      SRC_B    = 2'h2
   } lcc_src_t;
endpackage : lcc_pkg

/* File: rtl/lcc_reg_cell.sv */
// one register cell: edge select, polarity, enable, async force
`timescale 1ns/1ps
`default_nettype none
module lcc_reg_cell (
   // clock and reset
   input  wire logic       hclk,
   input  wire logic       hresetn,
   // clock network edges: 0 hard, 1 routed a, 2 routed b
   input  wire logic [2:0] net_rise,
   input  wire logic [2:0] net_fall,
   // configuration
   input  wire logic [1:0] src_sel,
   input  wire logic       falling,
   // user side
   input  wire logic       d,
   input  wire logic       enable_select_lo,
   input  wire logic       enable_select_hi,
   input  wire logic       clear,
   input  wire logic       preset,
   output logic            q
);
   logic q_reg;
   logic q_next;
   logic en;
   logic edge_hit;
   logic [1:0] idx;

   assign idx = (src_sel > 2'h2) ? 2'h0 : src_sel;
   assign edge_hit = falling ? net_fall[idx] : net_rise[idx];
   // enable from the two select lines
   assign en = enable_select_lo | enable_select_hi;

   always_comb begin
      if (clear)
         q_next = 1'b0;
      else if (preset)
         q_next = 1'b1;
      else if (edge_hit && en)
         q_next = d;
      else
         q_next = q_reg;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         q_reg <= 1'b0;
      else
         q_reg <= q_next;
   end

   // force acts without waiting for an edge
   assign q = clear ? 1'b0 : (preset ? 1'b1 : q_reg);

   property p_clear_low;
      @(posedge hclk) disable iff (!hresetn) clear |-> !q;
   endproperty
   a_clear_low: assert property (p_clear_low) else $error("clear did not force low");
   property p_preset_high;
      @(posedge hclk) disable iff (!hresetn) (preset && !clear) |-> q;
   endproperty
   a_preset_high: assert property (p_preset_high) else $error("preset did not force high");
   property p_hold;
      @(posedge hclk) disable iff (!hresetn)
         (!en && !clear && !preset) |=> (q_reg == $past(q_reg));
   endproperty
   a_hold: assert property (p_hold) else $error("value moved while disabled");
   property p_capture;
      @(posedge hclk) disable iff (!hresetn)
         (edge_hit && en && !clear && !preset) |=> (q_reg == $past(d));
   endproperty
   a_capture: assert property (p_capture) else $error("selected edge missed");
endmodule : lcc_reg_cell
`default_nettype wire

/* File: bench/lcc_pins_model.sv */
// clock pin model for the cell array: pins idle low between frames
`timescale 1ns/1ps
`default_nettype none
module lcc_pins_model (
   // clock
   input  wire logic hclk,
   // clock pins
   output var logic  hard_clock_pin,
   output var logic  routed_clock_a,
   output var logic  routed_clock_b
);
   initial begin
      hard_clock_pin = 1'b0;
      routed_clock_a = 1'b0;
      routed_clock_b = 1'b0;
   end
   // ----------------------------------------
   // pin driver
   // ----------------------------------------
   // one pin per network; a pin not driven stays at its fixed low
   task automatic drive(input int net, input logic v);
      @(posedge hclk);
      case (net)
         0: hard_clock_pin <= v;
         1: routed_clock_a <= v;
         default: routed_clock_b <= v;
      endcase
   endtask : drive
endmodule : lcc_pins_model
`default_nettype wire

/* File: bench/lcc_top_tb.sv */
// self-checking bench for the logic cell clocking block
`timescale 1ns/1ps
`default_nettype none
module lcc_top_tb;
   localparam int N = 4;
   logic         hclk, hresetn, hsel, hwrite, hreadyout, test_reset_pin;
   logic         pair_d, paired_cell_register, hard_clock_pin, routed_clock_a, routed_clock_b;
   logic         exp_pair, pd, a_int;
   logic [1:0]   htrans, hresp, comb_out;
   logic [2:0]   hsize;
   logic [7:0]   haddr;
   logic [31:0]  hwdata, hrdata, rd, lut0, lut1, ctrl, cfg, r;
   logic [N-1:0] cell_d, en_lo, en_hi, clr, pre, cell_q, exp_q;
   logic [4:0]   comb0_in, comb1_in;
   integer       seed;
   int           n_mismatch, n_compared, hard_cnt, strap;

   lcc_top #(.NUM_CELLS(N)) lcc_top_i (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .hard_clock_pin(hard_clock_pin), .routed_clock_a(routed_clock_a),
      .routed_clock_b(routed_clock_b), .test_reset_pin(test_reset_pin),
      .cell_d(cell_d), .enable_select_lo(en_lo), .enable_select_hi(en_hi),
      .cell_clear(clr), .cell_preset(pre), .cell_q(cell_q),
      .comb0_in(comb0_in), .comb1_in(comb1_in), .comb_out(comb_out),
      .pair_d(pair_d), .paired_cell_register(paired_cell_register));
   lcc_pins_model lcc_pins_model_i (.hclk(hclk), .hard_clock_pin(hard_clock_pin),
      .routed_clock_a(routed_clock_a), .routed_clock_b(routed_clock_b));

   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic give_verdict;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : give_verdict

   // single word transfer; waits on the slave, no fixed latency assumed
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= wr;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
      check(hresp, lcc_pkg::RESP_OKAY);
   endtask : ahb

   task automatic do_reset(input int s);
      hresetn        <= 1'b0;
      test_reset_pin <= s[0];
      strap    = s;
      hard_cnt = 0;
      exp_q    = '0;
      exp_pair = 1'b0;
      cfg      = '0;
      ctrl     = '0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
   endtask : do_reset

   // one level change on a network; the reference cells follow it
   task automatic edge_on(input int net, input logic lvl, input int hold, input logic [15:0] v);
      logic [3:0] cf;
      logic       pl;
      if (a_int && net == 1) begin
         @(posedge hclk);
         comb0_in <= {4'h0, lvl};
      end else
         lcc_pins_model_i.drive(net, lvl);
      cell_d <= v[3:0];
      en_lo  <= v[7:4];
      en_hi  <= v[11:8];
      pl = (ctrl[3:2] == net) ? lvl : 1'b0;
      // pair data only moves while the pair is not capturing
      if (pl == ctrl[4]) pd = v[12];
      pair_d <= pd;
      if (net == 0 && lvl) hard_cnt++;
      // hard edges dropped until the fourth rise unless strapped low
      if (net != 0 || strap == 0 || hard_cnt > 3) begin
         for (int i = 0; i < N; i++) begin
            cf = cfg[4*i +: 4];
            if (((cf[2:1] == 2'h3) ? 0 : int'(cf[2:1])) == net && cf[0] != lvl && (v[4+i] | v[8+i]))
               exp_q[i] = v[i];
         end
         // pair captures on its own edge
         if (ctrl[3:2] == net && pl != ctrl[4]) exp_pair = pd;
      end
      repeat (hold) @(posedge hclk);
   endtask : edge_on
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      {hsel, hwrite, pair_d, pd, a_int} = '0;
      {htrans, haddr, hwdata, comb0_in, comb1_in} = '0;
      {cell_d, en_lo, en_hi, clr, pre} = '0;
      hsize = 3'h2;
      n_mismatch = 0;
      n_compared = 0;
      seed = 32'hd26a;
      // strap low: hard clock live at once
      do_reset(0);
      edge_on(0, 1'b1, 3, 16'h0fff);
      edge_on(0, 1'b0, 3, 16'h0fff);
      check(cell_q, exp_q);
      ahb(1'b1, lcc_pkg::STATUS_OFS, 32'hffff_ffff);
      ahb(1'b1, 8'h18, 32'hffff_ffff);
      ahb(1'b0, lcc_pkg::STATUS_OFS, 32'h0);
      check(rd, 32'h200 | exp_q);
      // reset values, unmapped place included
      do_reset(1);
      for (int a = 0; a < 7; a++) begin
         ahb(1'b0, 8'(4 * a), 32'h0);
         check(rd, lcc_pkg::CTRL_RST);
      end
      // first three hard cycles do nothing
      for (int k = 0; k < 4; k++) begin
         edge_on(0, 1'b1, 2, 16'h0fff);
         edge_on(0, 1'b0, 2, 16'h0fff);
         check(cell_q, exp_q);
      end
      lut0 = $random(seed);
      lut1 = $random(seed);
      cfg  = 32'h0000_3520;
      ctrl = 32'h04;
      ahb(1'b1, lcc_pkg::COMB0_LUT_OFS, lut0);
      ahb(1'b1, lcc_pkg::COMB1_LUT_OFS, lut1);
      ahb(1'b1, lcc_pkg::COMB_CTRL_OFS, 32'h1);
      ahb(1'b1, lcc_pkg::CELL_CFG_OFS, cfg);
      ahb(1'b1, lcc_pkg::CLK_CTRL_OFS, ctrl);
      ahb(1'b0, lcc_pkg::COMB0_LUT_OFS, 32'h0);
      check(rd, lut0);
      ahb(1'b0, lcc_pkg::CELL_CFG_OFS, 32'h0);
      check(rd, cfg);
      for (int k = 0; k < 12; k++) begin
         r = $random(seed);
         @(posedge hclk);
         comb0_in <= r[4:0];
         comb1_in <= r[9:5];
         repeat (2) @(posedge hclk);
         check(comb_out, {lut1[r[9:5]], lut0[r[4:0] ^ 5'h1]});
      end
      // routed b into input 4 of cell 0, routed a into input 4 of cell 1
      ahb(1'b1, lcc_pkg::COMB_CTRL_OFS, 32'hd);
      comb0_in <= 5'h0;
      comb1_in <= 5'h0;
      edge_on(2, 1'b1, 3, 16'h0);
      check(comb_out[0], lut0[17]);
      edge_on(2, 1'b0, 3, 16'h0);
      check(comb_out[0], lut0[1]);
      edge_on(1, 1'b1, 3, 16'h0);
      check(comb_out[1], lut1[16]);
      edge_on(1, 1'b0, 3, 16'h0);
      check(comb_out[1], lut1[0]);
      // all three networks, both edges, prompt and slow pins
      for (int k = 0; k < 9; k++) begin
         if (k == 6) begin
            ctrl = 32'h18;
            exp_pair = pd;
            ahb(1'b1, lcc_pkg::CLK_CTRL_OFS, ctrl);
         end
         r = $random(seed);
         edge_on(k % 3, 1'b1, 2 + k % 2, r[15:0]);
         edge_on(k % 3, 1'b0, 2 + k % 2, r[31:16]);
         repeat (2) @(posedge hclk);
         check(cell_q, exp_q);
         check(paired_cell_register, exp_pair);
      end
      // network a from cell 0 output, its pin left low
      // lookup settles low first so switching the source makes no stray edge
      ctrl = 32'h19;
      ahb(1'b1, lcc_pkg::COMB_CTRL_OFS, 32'h0);
      ahb(1'b1, lcc_pkg::COMB0_LUT_OFS, 32'haaaa_aaaa);
      ahb(1'b1, lcc_pkg::CLK_CTRL_OFS, ctrl);
      a_int = 1'b1;
      for (int k = 0; k < 2; k++) begin
         r = $random(seed);
         edge_on(1, 1'b1, 3, r[15:0]);
         edge_on(1, 1'b0, 3, r[31:16]);
         repeat (2) @(posedge hclk);
         check(cell_q, exp_q);
      end
      for (int k = 0; k < 6; k++) begin
         r = (k == 0) ? 32'hf3 : $random(seed);
         @(posedge hclk);
         clr <= r[3:0];
         pre <= r[7:4];
         @(posedge hclk);
         check(cell_q & (r[3:0] | r[7:4]), r[7:4] & ~r[3:0]);
      end
      give_verdict();
   end

   // hang guard, far beyond the few hundred cycles of the run
   initial begin
      #200000;
      n_mismatch++;
      give_verdict();
   end
endmodule : lcc_top_tb
`default_nettype wire
